// ### rtl/fcrb_pkg.sv
// Constants, types and helper functions of the flash configuration register bank.
package fcrb_pkg;

    // ------------------------------------------------------------------
    // Register widths and reset values
    // ------------------------------------------------------------------
    localparam int          PERSIST_W       = 16;
    localparam int          RUNTIME_W       = 8;
    localparam int          CMD_W           = 8;
    localparam logic [15:0] PERSIST_RESET   = 16'hffff;
    localparam logic [7:0]  RUNTIME_RESET   = 8'hfb;

    // ------------------------------------------------------------------
    // Field positions of the persistent and runtime registers
    // ------------------------------------------------------------------
    localparam int P_DUMMY_LSB = 12;
    localparam int P_XIP_LSB   = 9;
    localparam int P_DRIVE_LSB = 6;
    localparam int P_SRT_BIT   = 5;
    localparam int P_HOLD_BIT  = 4;
    localparam int P_QUAD_BIT  = 3;
    localparam int P_DUAL_BIT  = 2;
    localparam int P_SEG_BIT   = 1;
    localparam int P_ADDR_BIT  = 0;
    localparam int R_DUMMY_LSB = 4;
    localparam int R_XIP_BIT   = 3;
    localparam int R_RSVD_BIT  = 2;
    localparam int R_WRAP_LSB  = 0;

    // ------------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------------
    localparam logic [3:0] DUMMY_ZERO_CODE   = 4'h0;
    localparam logic [3:0] DUMMY_ZERO_CYCLES = 4'hf;
    localparam logic [2:0] XIP_LAST_MODE     = 3'h4;
    localparam logic [1:0] WRAP_16           = 2'h0;
    localparam logic [1:0] WRAP_32           = 2'h1;
    localparam logic [1:0] WRAP_64           = 2'h2;
    localparam logic [1:0] WRAP_CONT         = 2'h3;
    localparam logic [1:0] SEG_LOWEST        = 2'h0;
    localparam logic [1:0] SEG_HIGHEST       = 2'h3;

    // Command codes; the values are arbitrary and meant to be overridden.
    localparam logic [7:0] CMD_RD_PERSIST_DEF = 8'h01;
    localparam logic [7:0] CMD_WR_PERSIST_DEF = 8'h02;
    localparam logic [7:0] CMD_RD_RUNTIME_DEF = 8'h03;
    localparam logic [7:0] CMD_WR_RUNTIME_DEF = 8'h04;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PROTO_EXT  = 3'b001,
        PROTO_DUAL = 3'b010,
        PROTO_QUAD = 3'b100
    } fcrb_proto_type;

    typedef enum logic [3:0] {
        LS_CMD  = 4'b0001,
        LS_WR   = 4'b0010,
        LS_RD   = 4'b0100,
        LS_SINK = 4'b1000
    } fcrb_lstate_type;

    typedef struct packed {
        logic [3:0]     dummy;
        logic           execute_in_place;
        logic [2:0]     xip_mode;
        logic [2:0]     drive;
        logic           single_rate_transfer;
        logic           data_line_three_hold;
        fcrb_proto_type proto;
        logic [1:0]     segment;
        logic           four_byte_addr;
        logic [1:0]     wrap;
    } fcrb_cfg_type;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Dummy code zero means fifteen cycles, every other code is literal.
    function automatic logic [3:0] dummy_map(input logic [3:0] code);
        return (code == DUMMY_ZERO_CODE) ? DUMMY_ZERO_CYCLES : code;
    endfunction

    // Quad wins over dual when both enables are cleared.
    function automatic fcrb_proto_type proto_of(input logic [15:0] p);
        if (!p[P_QUAD_BIT]) begin
            return PROTO_QUAD;
        end
        if (!p[P_DUAL_BIT]) begin
            return PROTO_DUAL;
        end
        return PROTO_EXT;
    endfunction

    // Internal configuration as downloaded from the persistent register.
    function automatic fcrb_cfg_type persist_to_cfg(input logic [15:0] p);
        fcrb_cfg_type c;
        c.dummy                = dummy_map(p[P_DUMMY_LSB +: 4]);
        c.execute_in_place     = (p[P_XIP_LSB +: 3] <= XIP_LAST_MODE);
        c.xip_mode             = p[P_XIP_LSB +: 3];
        c.drive                = p[P_DRIVE_LSB +: 3];
        c.single_rate_transfer = p[P_SRT_BIT];
        c.data_line_three_hold = p[P_HOLD_BIT];
        c.proto                = proto_of(p);
        c.segment              = p[P_SEG_BIT] ? SEG_LOWEST : SEG_HIGHEST;
        c.four_byte_addr       = !p[P_ADDR_BIT];
        c.wrap                 = RUNTIME_RESET[R_WRAP_LSB +: 2];
        return c;
    endfunction

endpackage

// ### rtl/fcrb_bank.sv
// Configuration register bank with a serial command port on the link clock.
`timescale 1ns/100ps
module fcrb_bank #(
    parameter int         ADDR_W        = 26,
    parameter logic [7:0] CMD_RD_PERSIST = fcrb_pkg::CMD_RD_PERSIST_DEF,
    parameter logic [7:0] CMD_WR_PERSIST = fcrb_pkg::CMD_WR_PERSIST_DEF,
    parameter logic [7:0] CMD_RD_RUNTIME = fcrb_pkg::CMD_RD_RUNTIME_DEF,
    parameter logic [7:0] CMD_WR_RUNTIME = fcrb_pkg::CMD_WR_RUNTIME_DEF
) (
    // System clock and resets.
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_por_rst,
    // Serial command link, in the link clock domain.
    input  wire logic                   i_link_clk,
    input  wire logic                   i_link_cs_n,
    input  wire logic                   i_link_din,
    output logic                        o_link_dout,
    output logic                        o_link_dout_oe,
    // Read address sequencer for the array.
    input  wire logic                   i_rd_load,
    input  wire logic [ADDR_W-1:0]      i_rd_start_addr,
    input  wire logic                   i_rd_advance,
    output logic [ADDR_W-1:0]           o_rd_addr,
    // Configuration seen by the rest of the memory.
    output fcrb_pkg::fcrb_cfg_type      o_cfg,
    output logic [15:0]                 o_persistent_config,
    output logic [7:0]                  o_runtime_config
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [4:0] LEN_PERSIST = 5'(fcrb_pkg::PERSIST_W);
    localparam logic [4:0] LEN_RUNTIME = 5'(fcrb_pkg::RUNTIME_W);
    localparam logic [4:0] LEN_CMD     = 5'(fcrb_pkg::CMD_W);

    logic                      rst_any_q;
    logic [15:0]               persist_q;
    logic [7:0]                runtime_q;
    fcrb_pkg::fcrb_cfg_type    cfg_q;
    logic [23:0]               snap_q;
    logic                      snap_tgl_q;
    logic                      wsync1_q, wsync2_q, wsync3_q;
    logic                      wr_evt;
    logic [ADDR_W-1:0]         rd_addr_q;

    logic                      lrst1_q, lrst2_q;
    logic                      ssync1_q, ssync2_q, ssync3_q;
    logic [23:0]               snap_lk_q;
    fcrb_pkg::fcrb_lstate_type lst_q;
    logic [4:0]                bitcnt_q;
    logic [4:0]                len_q;
    logic [15:0]               sh_q;
    logic [15:0]               out_q;
    logic                      dout_q, oe_q;
    logic                      wr_tgl_q;
    logic [15:0]               hold_q;
    logic                      hold_persist_q;
    logic [7:0]                cmd_byte;
    logic [15:0]               sh_next;

    // ------------------------------------------------------------------
    // System domain: resets and write event crossing
    // ------------------------------------------------------------------
    // Both resets are merged once here so the link side syncs a single level.
    always_ff @(posedge i_clk_sys) begin
        rst_any_q <= i_sys_rst | i_por_rst;
    end

    // Toggle from the link is synchronised; the held word is stable by then.
    // Any reset clears the chain, so the link side dropping its toggle is no write.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_por_rst) begin
            wsync1_q <= 1'b0;
            wsync2_q <= 1'b0;
            wsync3_q <= 1'b0;
        end else begin
            wsync1_q <= wr_tgl_q;
            wsync2_q <= wsync1_q;
            wsync3_q <= wsync2_q;
        end
    end
    assign wr_evt = wsync2_q ^ wsync3_q;

    // ------------------------------------------------------------------
    // System domain: the two registers
    // ------------------------------------------------------------------
    // The persistent register survives a plain reset; only power-on restores it.
    always_ff @(posedge i_clk_sys) begin
        if (i_por_rst) begin
            persist_q <= fcrb_pkg::PERSIST_RESET;
        end else if (wr_evt && hold_persist_q) begin
            persist_q <= hold_q;
        end
    end

    // The reserved runtime bit is forced to zero on every write.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_por_rst) begin
            runtime_q <= fcrb_pkg::RUNTIME_RESET;
        end else if (wr_evt && !hold_persist_q) begin
            runtime_q                       <= hold_q[7:0];
            runtime_q[fcrb_pkg::R_RSVD_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // System domain: internal configuration
    // ------------------------------------------------------------------
    // A persistent write only takes effect at the next plain reset, by design.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_por_rst) begin
            cfg_q <= fcrb_pkg::persist_to_cfg(persist_q);
        end else if (wr_evt && !hold_persist_q) begin
            cfg_q.dummy            <= fcrb_pkg::dummy_map(hold_q[fcrb_pkg::R_DUMMY_LSB +: 4]);
            cfg_q.execute_in_place <= !hold_q[fcrb_pkg::R_XIP_BIT];
            cfg_q.wrap             <= hold_q[fcrb_pkg::R_WRAP_LSB +: 2];
        end
    end

    // Snapshot for the link readback; it changes only with its toggle.
    always_ff @(posedge i_clk_sys) begin
        if (i_por_rst) begin
            snap_q     <= {fcrb_pkg::PERSIST_RESET, fcrb_pkg::RUNTIME_RESET};
            snap_tgl_q <= 1'b0;
        end else if (snap_q != {persist_q, runtime_q}) begin
            snap_q     <= {persist_q, runtime_q};
            snap_tgl_q <= ~snap_tgl_q;
        end
    end

    // ------------------------------------------------------------------
    // System domain: read address sequencer
    // ------------------------------------------------------------------
    // Next byte address: wrap inside the aligned block, or run on freely.
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a, input logic [1:0] w);
        logic [ADDR_W-1:0] m;
        m = '0;
        unique case (w)
            fcrb_pkg::WRAP_16: m = ADDR_W'(16'h000f);
            fcrb_pkg::WRAP_32: m = ADDR_W'(16'h001f);
            fcrb_pkg::WRAP_64: m = ADDR_W'(16'h003f);
            fcrb_pkg::WRAP_CONT: m = '1;
        endcase
        return (a & ~m) | ((a + ADDR_W'(1)) & m);
    endfunction

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || i_por_rst) begin
            rd_addr_q <= '0;
        end else if (i_rd_load) begin
            rd_addr_q <= i_rd_start_addr;
        end else if (i_rd_advance) begin
            rd_addr_q <= next_addr(rd_addr_q, cfg_q.wrap);
        end
    end

    assign o_cfg               = cfg_q;
    assign o_persistent_config = persist_q;
    assign o_runtime_config    = runtime_q;
    assign o_rd_addr           = rd_addr_q;

    // ------------------------------------------------------------------
    // Link domain: crossings in
    // ------------------------------------------------------------------
    // Reset is raised at once and lowered on the second link edge; the link clock
    // stops outside frames, so a purely clocked synchroniser would miss a short reset.
    always_ff @(posedge i_link_clk or posedge rst_any_q) begin
        if (rst_any_q) begin
            lrst1_q <= 1'b1;
            lrst2_q <= 1'b1;
        end else begin
            lrst1_q <= 1'b0;
            lrst2_q <= lrst1_q;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (lrst2_q) begin
            ssync1_q <= 1'b0;
            ssync2_q <= 1'b0;
            ssync3_q <= 1'b0;
        end else begin
            ssync1_q <= snap_tgl_q;
            ssync2_q <= ssync1_q;
            ssync3_q <= ssync2_q;
        end
    end

    // The snapshot word is held steady across its toggle's sync delay.
    // Reset takes the word as it stands, since a plain reset keeps the persistent value.
    always_ff @(posedge i_link_clk) begin
        if (lrst2_q) begin
            snap_lk_q <= snap_q;
        end else if (ssync2_q != ssync3_q) begin
            snap_lk_q <= snap_q;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: frame sequencer
    // ------------------------------------------------------------------
    assign sh_next  = {sh_q[14:0], i_link_din};
    assign cmd_byte = sh_next[7:0];

    // Chip select high ends the frame asynchronously; no edge is needed then.
    always_ff @(posedge i_link_clk or posedge i_link_cs_n) begin
        if (i_link_cs_n) begin
            lst_q    <= fcrb_pkg::LS_CMD;
            bitcnt_q <= '0;
            len_q    <= '0;
            sh_q     <= '0;
            out_q    <= '0;
            dout_q   <= 1'b0;
            oe_q     <= 1'b0;
        end else begin
            unique case (lst_q)
                fcrb_pkg::LS_CMD: begin
                    sh_q     <= sh_next;
                    bitcnt_q <= bitcnt_q + 5'd1;
                    if (bitcnt_q == LEN_CMD - 5'd1) begin
                        bitcnt_q <= '0;
                        lst_q    <= fcrb_pkg::LS_SINK;
                        if (cmd_byte == CMD_WR_PERSIST || cmd_byte == CMD_WR_RUNTIME) begin
                            lst_q <= fcrb_pkg::LS_WR;
                            len_q <= (cmd_byte == CMD_WR_PERSIST) ? LEN_PERSIST : LEN_RUNTIME;
                        end else if (cmd_byte == CMD_RD_PERSIST) begin
                            lst_q  <= fcrb_pkg::LS_RD;
                            len_q  <= LEN_PERSIST;
                            out_q  <= {snap_lk_q[22:8], 1'b0};
                            dout_q <= snap_lk_q[23];
                            oe_q   <= 1'b1;
                        end else if (cmd_byte == CMD_RD_RUNTIME) begin
                            lst_q  <= fcrb_pkg::LS_RD;
                            len_q  <= LEN_RUNTIME;
                            out_q  <= {snap_lk_q[6:0], 9'h000};
                            dout_q <= snap_lk_q[7];
                            oe_q   <= 1'b1;
                        end
                    end
                end
                fcrb_pkg::LS_WR: begin
                    sh_q     <= sh_next;
                    bitcnt_q <= bitcnt_q + 5'd1;
                    if (bitcnt_q == len_q - 5'd1) begin
                        lst_q <= fcrb_pkg::LS_SINK;
                    end
                end
                fcrb_pkg::LS_RD: begin
                    bitcnt_q <= bitcnt_q + 5'd1;
                    out_q    <= {out_q[14:0], 1'b0};
                    dout_q   <= out_q[15];
                    if (bitcnt_q == len_q - 5'd1) begin
                        lst_q  <= fcrb_pkg::LS_SINK;
                        oe_q   <= 1'b0;
                        dout_q <= 1'b0;
                    end
                end
                fcrb_pkg::LS_SINK: begin
                    bitcnt_q <= bitcnt_q;
                end
            endcase
        end
    end

    // Completed writes are held here, outside the frame reset, and toggled over.
    always_ff @(posedge i_link_clk or posedge lrst2_q) begin
        if (lrst2_q) begin
            wr_tgl_q       <= 1'b0;
            hold_q         <= '0;
            hold_persist_q <= 1'b0;
        end else if (lst_q == fcrb_pkg::LS_WR && bitcnt_q == len_q - 5'd1) begin
            wr_tgl_q       <= ~wr_tgl_q;
            hold_q         <= sh_next;
            hold_persist_q <= (len_q == LEN_PERSIST);
        end
    end

    assign o_link_dout    = dout_q;
    assign o_link_dout_oe = oe_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_dummy_nonzero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || i_por_rst)
        cfg_q.dummy != 4'h0) else $error("dummy cycle count reads zero");
    chk_reset_download: assert property (@(posedge i_clk_sys)
        (i_sys_rst && !i_por_rst) |=> cfg_q.dummy == fcrb_pkg::dummy_map(persist_q[15:12])
        && cfg_q.four_byte_addr == !persist_q[0]) else $error("reset did not download persistent fields");
    chk_quad_priority: assert property (@(posedge i_clk_sys)
        (i_sys_rst && !persist_q[3] && !persist_q[2]) |=> cfg_q.proto == fcrb_pkg::PROTO_QUAD)
        else $error("quad protocol not chosen over dual");
    chk_runtime_apply: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || i_por_rst)
        (wr_evt && !hold_persist_q) |=> cfg_q.wrap == runtime_q[1:0]
        && cfg_q.execute_in_place == !runtime_q[3]) else $error("runtime write not applied");
    chk_persist_defer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || i_por_rst)
        (wr_evt && hold_persist_q) |=> $stable(cfg_q)) else $error("persistent write changed live config");
    chk_wrap_block: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || i_por_rst)
        (i_rd_advance && !i_rd_load && cfg_q.wrap == fcrb_pkg::WRAP_16)
        |=> rd_addr_q[ADDR_W-1:4] == $past(rd_addr_q[ADDR_W-1:4])
        && rd_addr_q[3:0] == $past(rd_addr_q[3:0]) + 4'h1) else $error("16-byte wrap left its block");
    chk_segment_default: assert property (@(posedge i_clk_sys)
        (i_sys_rst && !i_por_rst) |=> cfg_q.segment == ($past(persist_q[fcrb_pkg::P_SEG_BIT])
        ? fcrb_pkg::SEG_LOWEST : fcrb_pkg::SEG_HIGHEST)) else $error("default segment wrong");
    chk_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_por_rst)
        wr_evt |=> runtime_q[2] == 1'b0) else $error("reserved runtime bit not zero");
    chk_read_drive: assert property (@(posedge i_link_clk) disable iff (i_link_cs_n)
        (lst_q == fcrb_pkg::LS_CMD && bitcnt_q == 5'd7 && sh_next[7:0] == CMD_RD_PERSIST)
        |=> oe_q [*8]) else $error("persistent readback not driven");

    cov_persist_write: cover property (@(posedge i_clk_sys) wr_evt && hold_persist_q);
    cov_runtime_write: cover property (@(posedge i_clk_sys) wr_evt && !hold_persist_q);
    cov_wrap_turn: cover property (@(posedge i_clk_sys) i_rd_advance && cfg_q.wrap == fcrb_pkg::WRAP_16
        && rd_addr_q[3:0] == 4'hf);
    cov_link_read: cover property (@(posedge i_link_clk) lst_q == fcrb_pkg::LS_RD);

endmodule

// ### rtl/fcrb_unused_guard.sv
// Intentionally empty: all logic lives in fcrb_bank.
`timescale 1ns/100ps

// ### dv/fcrb_host.sv
// Host serial controller model for the configuration link.
`timescale 1ns/100ps
module fcrb_host (
    // Link towards the device.
    output logic      o_link_clk,
    output logic      o_link_cs_n,
    output logic      o_link_din,
    input  wire logic i_link_dout
);
    // ----------------------------------------------------------------
    // Frames
    // ----------------------------------------------------------------
    // The link clock stands still between frames, apart from the idle clocks after a reset.
    initial begin
        o_link_clk  = 1'b0;
        o_link_cs_n = 1'b1;
        o_link_din  = 1'b0;
    end

    // Idle clocks with the select high let the reset reach the link side.
    task automatic idle(input int n);
        // A small offset keeps link edges off the system clock edges.
        #7;
        repeat (n) begin
            #80 o_link_clk = 1'b1;
            #80 o_link_clk = 1'b0;
        end
    endtask

    // Command then nb data bits, MSB first; read bits are taken just after each falling edge, half a period before the rising edge.
    // No fast read is issued, so any dummy code is safe at this link rate.
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int nb, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd << (16 - nb)};
        rd = 16'h0000;
        #7 o_link_cs_n = 1'b0;
        for (int i = 0; i < 8 + nb; i++) begin
            o_link_din = sh[23-i];
            if (i >= 8) begin
                rd = {rd[14:0], i_link_dout};
            end
            #80 o_link_clk = 1'b1;
            #80 o_link_clk = 1'b0;
        end
        #80 o_link_cs_n = 1'b1;
        o_link_din = ~o_link_din;
        // Select stays high for a while so frames never touch and writes can commit.
        #80;
    endtask
endmodule

// ### dv/fcrb_bank_tb.sv
// Self-checking bench for the flash configuration register bank.
`timescale 1ns/100ps
module fcrb_bank_tb;
    logic                   clk = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, ld = 1'b0, adv = 1'b0;
    logic [25:0]            sa = 26'h0, ra, m;
    logic                   lclk, cs_n, din, dout, oe;
    logic [15:0]            pq, rd;
    logic [7:0]             rq, r;
    logic [15:0]            pv [2] = '{16'h0840, 16'h1afb};
    fcrb_pkg::fcrb_cfg_type cfg, ec;
    int                     error_cnt = 0;
    int                     compares = 0;

    // ----------------------------------------------------------------
    // Clock and instances
    // ----------------------------------------------------------------
    // System clock of 5 ns.
    always #2.5 clk = ~clk;

    fcrb_bank fcrb_bank_i (.i_clk_sys(clk), .i_sys_rst(sys_rst), .i_por_rst(por_rst), .i_link_clk(lclk),
        .i_link_cs_n(cs_n), .i_link_din(din), .o_link_dout(dout), .o_link_dout_oe(oe), .i_rd_load(ld),
        .i_rd_start_addr(sa), .i_rd_advance(adv), .o_rd_addr(ra), .o_cfg(cfg), .o_persistent_config(pq),
        .o_runtime_config(rq));
    fcrb_host fcrb_host_i (.o_link_clk(lclk), .o_link_cs_n(cs_n), .o_link_din(din), .i_link_dout(dout));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Reset for five cycles, then idle link clocks so the link side leaves reset too.
    task automatic rst(input logic por);
        if (!sys_rst) begin
            @(negedge clk);
        end
        sys_rst = 1'b1;
        por_rst = por;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        por_rst = 1'b0;
        fcrb_host_i.idle(4);
    endtask

    // Live configuration that a download of persistent value p must give.
    function automatic fcrb_pkg::fcrb_cfg_type exp_cfg(input logic [15:0] p);
        fcrb_pkg::fcrb_cfg_type c;
        c.dummy = (p[15:12] == 4'h0) ? 4'hf : p[15:12];
        c.execute_in_place = (p[11:9] <= 3'h4);
        c.xip_mode = p[11:9];
        c.drive = p[8:6];
        c.single_rate_transfer = p[5];
        c.data_line_three_hold = p[4];
        c.proto = !p[3] ? fcrb_pkg::PROTO_QUAD : !p[2] ? fcrb_pkg::PROTO_DUAL : fcrb_pkg::PROTO_EXT;
        c.segment = p[1] ? 2'h0 : 2'h3;
        c.four_byte_addr = !p[0];
        c.wrap = 2'h3;
        return c;
    endfunction

    // Outputs first, then both registers read back over the link.
    task automatic chk_regs(input logic [15:0] p, input logic [7:0] r, input fcrb_pkg::fcrb_cfg_type c);
        @(negedge clk);
        chk("persistent", {16'h0, p}, {16'h0, pq});
        chk("runtime", {24'h0, r}, {24'h0, rq});
        chk("cfg", {11'h0, c}, {11'h0, cfg});
        fcrb_host_i.frame(fcrb_pkg::CMD_RD_PERSIST_DEF, 16'h0, 16, rd);
        chk("read persistent", {16'h0, p}, {16'h0, rd});
        fcrb_host_i.frame(fcrb_pkg::CMD_RD_RUNTIME_DEF, 16'h0, 8, rd);
        chk("read runtime", {24'h0, r}, {24'h0, rd[7:0]});
        chk("dout enable", 32'h0, {31'h0, oe});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    // Defaults, persistent downloads, runtime overrides with wrapped reads, and power-on again.
    initial begin
        rst(1'b1);
        ec = exp_cfg(16'hffff);
        chk_regs(16'hffff, 8'hfb, ec);
        foreach (pv[i]) begin
            fcrb_host_i.frame(fcrb_pkg::CMD_WR_PERSIST_DEF, pv[i], 16, rd);
            chk_regs(pv[i], 8'hfb, ec);
            rst(1'b0);
            ec = exp_cfg(pv[i]);
            chk_regs(pv[i], 8'hfb, ec);
        end
        // An aborted write must leave the register alone.
        fcrb_host_i.frame(fcrb_pkg::CMD_WR_PERSIST_DEF, 16'h0, 9, rd);
        chk_regs(16'h1afb, 8'hfb, ec);
        for (int w = 0; w < 4; w++) begin
            r = {2'h0, 2'(w), w[0], 1'b1, 2'(w)};
            fcrb_host_i.frame(fcrb_pkg::CMD_WR_RUNTIME_DEF, {8'h0, r}, 8, rd);
            r[2] = 1'b0;
            ec.dummy = (w == 0) ? 4'hf : 4'(w);
            ec.execute_in_place = !r[3];
            ec.wrap = 2'(w);
            chk_regs(16'h1afb, r, ec);
            m = (w == 3) ? '1 : 26'((16 << w) - 1);
            @(negedge clk);
            sa = 26'h13d;
            ld = 1'b1;
            for (int n = 0; n < 6; n++) begin
                @(negedge clk);
                chk("read address", {6'h0, (sa & ~m) | ((sa + 26'(n)) & m)}, {6'h0, ra});
                ld = 1'b0;
                adv = 1'b1;
            end
            adv = 1'b0;
        end
        rst(1'b1);
        chk_regs(16'hffff, 8'hfb, exp_cfg(16'hffff));
        test_done;
    end

    // A hang ends the run as a failure.
    initial begin
        #400us;
        error_cnt++;
        test_done;
    end
endmodule
